//--- design/rtm_host.sv
// host controller for an 8-bit prescaler / 8-bit reload timer
// assumes device ticks and pin levels are synchronous to clock
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rtm_host #(
  parameter int TRIG_CYCLES = rtm_pkg::TRIG_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // device register port
  output logic             devWrite,
  output logic [2:0]       devAddr,
  output logic [7:0]       devWdata,
  // device timing and pins
  input  wire logic        countTick,
  input  wire logic        underflowTick,
  input  wire logic        waveformPin,
  output logic             triggerPin
);

  if (TRIG_CYCLES < 1 || TRIG_CYCLES > 15)
  begin : g_chk
    $error("TRIG_CYCLES out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_LWAIT, S_WSEC, S_WPRI, S_FRESH, S_TRIG
  } rtm_state_type;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  rtm_state_type state;
  logic [7:0]    preVal;
  logic [7:0]    priVal;
  logic [7:0]    secVal;
  logic [1:0]    modeVal;
  logic          refused;
  logic          counting;
  logic          pinPrev;
  logic [1:0]    preGap;
  logic [1:0]    priGap;
  logic          priFresh;
  logic          isTrig;
  logic [3:0]    trigCnt;
  logic          busWr;
  logic          rdPend;
  logic [7:0]    busAddr;
  logic          cmdTake;
  logic          cmdRefuse;
  logic          primStart;
  logic          waveSync;
  logic [7:0]    preShadow;
  logic          edgeSeen;
  logic [1:0]    priPerCycle;
  logic [3:0]    trigHigh;

  function automatic logic isDevWr(input logic w, input logic [2:0] a,
                                   input logic [2:0] r);
    return w && (a == r);
  endfunction

  // ahb address phase capture; reads take one wait state
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      busWr   <= 1'b0;
      rdPend  <= 1'b0;
      busAddr <= 8'h00;
    end
    else
    begin
      busWr  <= 1'b0;
      rdPend <= 1'b0;
      if (hsel && htrans[1] && hready)
      begin
        busWr   <= hwrite;
        rdPend  <= !hwrite;
        busAddr <= haddr[7:0];
      end
    end
  end

  assign hreadyout = !rdPend;
  assign hresp     = 1'b0;

  // read data, registered during the wait state
  always_ff @(posedge clock)
  begin
    if (!nrst)
      hrdata <= 32'h0000_0000;
    else if (rdPend)
    begin
      hrdata <= 32'h0000_0000;
      unique case (busAddr)
        rtm_pkg::A_PRE:  hrdata[7:0] <= preVal;
        rtm_pkg::A_PRI:  hrdata[7:0] <= priVal;
        rtm_pkg::A_SEC:  hrdata[7:0] <= secVal;
        rtm_pkg::A_MODE: hrdata[1:0] <= modeVal;
        rtm_pkg::A_STAT:
        begin
          hrdata[rtm_pkg::ST_BUSY]  <= (state != S_IDLE);
          hrdata[rtm_pkg::ST_REFUS] <= refused;
          hrdata[rtm_pkg::ST_PIN]   <= waveformPin;
          hrdata[rtm_pkg::ST_COUNT] <= counting;
        end
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // value registers written by software
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      preVal  <= rtm_pkg::PRE_RESET;
      priVal  <= rtm_pkg::PRI_RESET;
      secVal  <= 8'h00;
      modeVal <= rtm_pkg::MODE_TIMER;
    end
    else if (busWr)
    begin
      if (busAddr == rtm_pkg::A_PRE)
        preVal <= hwdata[7:0];
      if (busAddr == rtm_pkg::A_PRI)
        priVal <= hwdata[7:0];
      if (busAddr == rtm_pkg::A_SEC)
        secVal <= hwdata[7:0];
      if (busAddr == rtm_pkg::A_MODE)
        modeVal <= hwdata[1:0];
    end
  end

  assign cmdTake = busWr && (busAddr == rtm_pkg::A_CMD)
                   && (hwdata[2:0] != 3'h0);
  // zero reload pair in one-shot modes is refused, as is a busy command
  assign cmdRefuse = cmdTake && ((state != S_IDLE)
    || (hwdata[2:0] == rtm_pkg::CMD_LOAD && modeVal[1]
        && preVal == 8'h00 && priVal == 8'h00));

  // sticky refusal flag, write one to clear, set wins
  always_ff @(posedge clock)
  begin
    if (!nrst)
      refused <= 1'b0;
    else if (cmdRefuse)
      refused <= 1'b1;
    else if (busWr && busAddr == rtm_pkg::A_STAT
             && hwdata[rtm_pkg::ST_REFUS])
      refused <= 1'b0;
  end

  // primary period start seen as a rising output level
  always_ff @(posedge clock)
  begin
    if (!nrst)
      pinPrev <= 1'b0;
    else
      pinPrev <= waveformPin;
  end

  assign primStart = waveformPin && !pinPrev;
  assign waveSync  = counting && (modeVal == rtm_pkg::MODE_WAVE);

  // spacing counters since the last reload writes
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      preGap   <= rtm_pkg::GAP_MIN;
      priGap   <= rtm_pkg::GAP_MIN;
      priFresh <= 1'b0;
    end
    else
    begin
      if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRE))
        preGap <= 2'h0;
      else if (countTick && preGap != rtm_pkg::GAP_MIN)
        preGap <= preGap + 2'h1;
      if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRI))
        priGap <= 2'h0;
      else if (underflowTick && priGap != rtm_pkg::GAP_MIN)
        priGap <= priGap + 2'h1;
      if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRI))
        priFresh <= 1'b1;
      else if (countTick)
        priFresh <= 1'b0;
    end
  end

  // command sequencer and device register port
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state      <= S_IDLE;
      devWrite   <= 1'b0;
      devAddr    <= 3'h0;
      devWdata   <= 8'h00;
      counting   <= 1'b0;
      isTrig     <= 1'b0;
      trigCnt    <= 4'h0;
      triggerPin <= 1'b0;
    end
    else
    begin
      devWrite <= 1'b0;
      unique case (state)
        S_IDLE:
          if (cmdTake && !cmdRefuse)
          begin
            unique case (hwdata[2:0])
              rtm_pkg::CMD_LOAD: state <= S_LWAIT;
              rtm_pkg::CMD_MODE:
              begin
                devWrite <= 1'b1;
                devAddr  <= rtm_pkg::DEV_MODE;
                devWdata <= {6'h00, modeVal};
              end
              rtm_pkg::CMD_START:
              begin
                devWrite <= 1'b1;
                devAddr  <= rtm_pkg::DEV_TCTRL;
                devWdata <= 8'h01 << rtm_pkg::TC_START;
                counting <= 1'b1;
              end
              rtm_pkg::CMD_STOP:
              begin
                devWrite <= 1'b1;
                devAddr  <= rtm_pkg::DEV_TCTRL;
                devWdata <= 8'h01 << rtm_pkg::TC_STOP;
                counting <= 1'b0;
              end
              rtm_pkg::CMD_OSSTOP:
              begin
                devWrite <= 1'b1;
                devAddr  <= rtm_pkg::DEV_OSCTRL;
                devWdata <= 8'h01 << rtm_pkg::OS_STOP;
              end
              rtm_pkg::CMD_OSSTART:
              begin
                isTrig <= 1'b0;
                state  <= S_FRESH;
              end
              default:
              begin
                isTrig <= 1'b1;
                state  <= S_FRESH;
              end
            endcase
          end
        // wait for spacing while counting (a stopped timer never
        // underflows), and in waveform mode for a primary start
        S_LWAIT:
          if ((!counting || (preGap == rtm_pkg::GAP_MIN
                             && priGap == rtm_pkg::GAP_MIN))
              && (!waveSync || primStart))
          begin
            devWrite <= 1'b1;
            devAddr  <= rtm_pkg::DEV_PRE;
            devWdata <= preVal;
            state    <= S_WSEC;
          end
        S_WSEC:
        begin
          devWrite <= 1'b1;
          devAddr  <= rtm_pkg::DEV_SEC;
          devWdata <= secVal;
          state    <= S_WPRI;
        end
        S_WPRI:
        begin
          devWrite <= 1'b1;
          devAddr  <= rtm_pkg::DEV_PRI;
          devWdata <= priVal;
          state    <= S_IDLE;
        end
        // hold one-shot starts until a tick after the primary write
        S_FRESH:
          if (!priFresh)
          begin
            if (isTrig)
            begin
              triggerPin <= 1'b1;
              trigCnt    <= 4'(TRIG_CYCLES - 1);
              state      <= S_TRIG;
            end
            else
            begin
              devWrite <= 1'b1;
              devAddr  <= rtm_pkg::DEV_OSCTRL;
              devWdata <= 8'h01 << rtm_pkg::OS_START;
              state    <= S_IDLE;
            end
          end
        S_TRIG:
          if (trigCnt == 4'h0)
          begin
            triggerPin <= 1'b0;
            state      <= S_IDLE;
          end
          else
            trigCnt <= trigCnt - 4'h1;
        default: state <= S_IDLE;
      endcase
    end
  end

  // checking aid: device prescaler value and per-cycle update count
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      preShadow   <= rtm_pkg::PRE_RESET;
      edgeSeen    <= 1'b0;
      priPerCycle <= 2'h0;
    end
    else
    begin
      if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRE))
        preShadow <= devWdata;
      else if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_TCTRL)
               && devWdata[rtm_pkg::TC_STOP])
        preShadow <= rtm_pkg::PRE_RESET;
      if (primStart)
        edgeSeen <= 1'b1;
      else if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRI))
        edgeSeen <= 1'b0;
      if (primStart)
        priPerCycle <= 2'h0;
      else if (isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRI)
               && priPerCycle != 2'h3)
        priPerCycle <= priPerCycle + 2'h1;
    end
  end

  // checking aid: length of the current trigger pulse, saturating
  always_ff @(posedge clock)
  begin
    if (!nrst || !triggerPin)
      trigHigh <= 4'h0;
    else if (trigHigh != 4'hF)
      trigHigh <= trigHigh + 4'h1;
  end

  sequence secWr;
    isDevWr(devWrite, devAddr, rtm_pkg::DEV_SEC);
  endsequence
  sequence priWr;
    isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRI);
  endsequence

  a_pre_spacing: assert property (
    isDevWr(devWrite, devAddr, rtm_pkg::DEV_PRE) && counting
    |-> preGap == rtm_pkg::GAP_MIN)
    else $error("prescaler rewritten too soon");
  a_pri_spacing: assert property (
    priWr and counting |-> priGap == rtm_pkg::GAP_MIN)
    else $error("primary rewritten too soon");
  a_wave_sync: assert property (
    secWr and waveSync |-> edgeSeen)
    else $error("waveform update not after primary start");
  a_once_cycle: assert property (
    waveSync && priPerCycle != 2'h0 |-> not priWr)
    else $error("second update within one output cycle");
  a_sec_then_pri: assert property (
    secWr |=> priWr)
    else $error("primary did not follow secondary");
  a_stop_force: assert property (
    isDevWr(devWrite, devAddr, rtm_pkg::DEV_TCTRL)
    && !devWdata[rtm_pkg::TC_START] |-> devWdata[rtm_pkg::TC_STOP])
    else $error("stop without force stop");
  a_zero_pair: assert property (
    priWr and modeVal[1] |-> !(devWdata == 8'h00 && preShadow == 8'h00))
    else $error("both reloads zero in one-shot mode");
  a_trig_gap: assert property (
    $rose(triggerPin) |-> !$past(priFresh))
    else $error("trigger too soon after primary write");
  a_trig_len: assert property (
    $fell(triggerPin) |-> trigHigh == 4'(TRIG_CYCLES))
    else $error("trigger pulse length wrong");
  a_sw_gap: assert property (
    isDevWr(devWrite, devAddr, rtm_pkg::DEV_OSCTRL)
    && devWdata[rtm_pkg::OS_START] |-> !$past(priFresh))
    else $error("one-shot start too soon after primary write");

endmodule // rtm_host

`default_nettype wire

//--- design/rtm_pkg.sv
// constants shared by the reload timer host controller
// assumes a device register port with 8-bit data and 3-bit register index
package rtm_pkg;

  // device register index
  localparam logic [2:0] DEV_TCTRL  = 3'h0;
  localparam logic [2:0] DEV_OSCTRL = 3'h1;
  localparam logic [2:0] DEV_PRE    = 3'h2;
  localparam logic [2:0] DEV_SEC    = 3'h3;
  localparam logic [2:0] DEV_PRI    = 3'h4;
  localparam logic [2:0] DEV_MODE   = 3'h5;

  // timer control fields
  localparam int TC_START = 0;
  localparam int TC_STOP  = 2;
  // one-shot control fields
  localparam int OS_START = 0;
  localparam int OS_STOP  = 1;

  // device reload values after reset or force stop
  localparam logic [7:0] PRE_RESET = 8'hFF;
  localparam logic [7:0] PRI_RESET = 8'hFF;

  // least write spacing, in count-source ticks or underflows
  localparam logic [1:0] GAP_MIN = 2'h3;

  // timer modes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WAVE  = 2'h1;
  localparam logic [1:0] MODE_OS    = 2'h2;
  localparam logic [1:0] MODE_WAIT  = 2'h3;

  // host commands
  localparam logic [2:0] CMD_LOAD    = 3'h1;
  localparam logic [2:0] CMD_MODE    = 3'h2;
  localparam logic [2:0] CMD_START   = 3'h3;
  localparam logic [2:0] CMD_STOP    = 3'h4;
  localparam logic [2:0] CMD_OSSTART = 3'h5;
  localparam logic [2:0] CMD_OSSTOP  = 3'h6;
  localparam logic [2:0] CMD_TRIG    = 3'h7;

  // host register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_PRE  = 8'h04;
  localparam logic [7:0] A_PRI  = 8'h08;
  localparam logic [7:0] A_SEC  = 8'h0C;
  localparam logic [7:0] A_MODE = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;

  // status fields
  localparam int ST_BUSY  = 0;
  localparam int ST_REFUS = 1;
  localparam int ST_PIN   = 2;
  localparam int ST_COUNT = 3;

  // default trigger pulse length in clocks
  localparam int TRIG_CYCLES = 2;

endpackage

//--- verif/rtm_dev_model.sv
// device model: 8-bit prescaler and reload timer behind the host
// assumes register writes and pins are synchronous to clock
`timescale 1ns/1ps
`default_nettype none

module rtm_dev_model #(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // register port
  input  wire logic       devWrite,
  input  wire logic [2:0] devAddr,
  input  wire logic [7:0] devWdata,
  // timing and pins
  input  wire logic       triggerPin,
  output logic            countTick,
  output logic            underflowTick,
  output logic            waveformPin,
  // state shown to the bench
  output logic [7:0]      preReg,
  output logic [7:0]      priReg,
  output logic [7:0]      secReg,
  output logic [1:0]      modeReg,
  output logic            running,
  output logic [7:0]      badCount
);
  logic [3:0] divCnt;
  logic [7:0] preCnt;
  logic [7:0] priCnt;
  logic [1:0] preGap;
  logic [1:0] priGap;
  logic       tickSeen;
  logic       trigPrev;
  logic       statMid;
  logic       statFlag;
  logic       osFlag;
  logic       preWr;
  logic       priWr;
  logic       stopWr;
  logic       bad;

  // write decode
  assign preWr  = devWrite && devAddr == rtm_pkg::DEV_PRE;
  assign priWr  = devWrite && devAddr == rtm_pkg::DEV_PRI;
  assign stopWr = devWrite && devAddr == rtm_pkg::DEV_TCTRL
                  && devWdata[rtm_pkg::TC_STOP];

  // count source tick every TICK_DIV clocks
  always_ff @(posedge clock)
  begin
    if (!nrst || divCnt == 4'(TICK_DIV - 1))
      divCnt <= 4'h0;
    else
      divCnt <= divCnt + 4'h1;
  end
  assign countTick = divCnt == 4'h0;
  assign underflowTick = countTick && statFlag && preCnt == 8'h00;

  // device registers
  always_ff @(posedge clock)
  begin
    if (!nrst || stopWr)
    begin
      preReg <= rtm_pkg::PRE_RESET;
      priReg <= rtm_pkg::PRI_RESET;
    end
    else if (preWr)
      preReg <= devWdata;
    else if (priWr)
      priReg <= devWdata;
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      secReg <= 8'h00;
      modeReg <= 2'h0;
      running <= 1'b0;
    end
    else if (devWrite && devAddr == rtm_pkg::DEV_SEC)
      secReg <= devWdata;
    else if (devWrite && devAddr == rtm_pkg::DEV_MODE)
      modeReg <= devWdata[1:0];
    else if (devWrite && devAddr == rtm_pkg::DEV_TCTRL)
      running <= devWdata[rtm_pkg::TC_START] && !stopWr;
  end

  // count status lags start by one to two ticks, stop acts at once
  always_ff @(posedge clock)
  begin
    if (!nrst || stopWr)
    begin
      statMid <= 1'b0;
      statFlag <= 1'b0;
    end
    else if (countTick)
    begin
      statMid <= running;
      statFlag <= statMid;
    end
  end

  // one-shot status takes the control write only if it lands on a count-source tick
  always_ff @(posedge clock)
  begin
    if (!nrst)
      osFlag <= 1'b0;
    else if (countTick && devWrite && devAddr == rtm_pkg::DEV_OSCTRL)
      osFlag <= devWdata[rtm_pkg::OS_START];
  end

  // counters; the pin flips at each period end in waveform mode
  always_ff @(posedge clock)
  begin
    if (!nrst || !statFlag || (devWrite && devAddr == rtm_pkg::DEV_OSCTRL
        && devWdata[rtm_pkg::OS_STOP]))
    begin
      preCnt <= preReg;
      priCnt <= secReg;
      waveformPin <= 1'b0;
    end
    else if (countTick && preCnt != 8'h00)
      preCnt <= preCnt - 8'h01;
    else if (countTick)
    begin
      preCnt <= preReg;
      priCnt <= priCnt - 8'h01;
      if (priCnt == 8'h00 && modeReg == rtm_pkg::MODE_WAVE)
      begin
        waveformPin <= !waveformPin;
        priCnt <= waveformPin ? secReg : priReg;
      end
    end
  end

  // host misuse: spacing, zero reloads, late period writes, early start
  assign bad = (preWr && statFlag && preGap != rtm_pkg::GAP_MIN)
    || (priWr && statFlag && priGap != rtm_pkg::GAP_MIN)
    || (priWr && modeReg[1] && preReg == 8'h00
        && devWdata == 8'h00)
    || (priWr && statFlag && modeReg == rtm_pkg::MODE_WAVE
        && !waveformPin)
    || (!tickSeen && ((triggerPin && !trigPrev) || (devWrite
        && devAddr == rtm_pkg::DEV_OSCTRL)));
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      badCount <= 8'h00;
      preGap <= rtm_pkg::GAP_MIN;
      priGap <= rtm_pkg::GAP_MIN;
      tickSeen <= 1'b1;
      trigPrev <= 1'b0;
    end
    else
    begin
      trigPrev <= triggerPin;
      badCount <= badCount + {7'h00, bad};
      if (preWr)
        preGap <= 2'h0;
      else if (countTick && preGap != rtm_pkg::GAP_MIN)
        preGap <= preGap + 2'h1;
      if (priWr)
        priGap <= 2'h0;
      else if (underflowTick && priGap != rtm_pkg::GAP_MIN)
        priGap <= priGap + 2'h1;
      if (priWr)
        tickSeen <= 1'b0;
      else if (countTick)
        tickSeen <= 1'b1;
    end
  end
endmodule // rtm_dev_model

`default_nettype wire

//--- verif/rtm_host_tb_top.sv
// bench for the reload timer host: ahb master, device model, scenarios
// assumes the device model answers on the host's device port
`timescale 1ns/1ps
`default_nettype none

module rtm_host_tb_top;
  logic        clock;
  logic        nrst;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        devWrite;
  logic        triggerPin;
  logic        countTick;
  logic        underflowTick;
  logic        waveformPin;
  logic        running;
  logic [1:0]  htrans;
  logic [1:0]  modeReg;
  logic [2:0]  devAddr;
  logic [7:0]  devWdata;
  logic [7:0]  preReg;
  logic [7:0]  priReg;
  logic [7:0]  secReg;
  logic [7:0]  badCount;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          fail_count;
  int          compares;

  // host under test with a three-cycle trigger pulse
  rtm_host #(.TRIG_CYCLES(3)) DUT (.clock(clock), .nrst(nrst),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .devWrite(devWrite), .devAddr(devAddr), .devWdata(devWdata),
    .countTick(countTick), .underflowTick(underflowTick),
    .waveformPin(waveformPin), .triggerPin(triggerPin));

  // device on the far side
  rtm_dev_model #(.TICK_DIV(4)) devModel (.clock(clock), .nrst(nrst),
    .devWrite(devWrite), .devAddr(devAddr), .devWdata(devWdata),
    .triggerPin(triggerPin), .countTick(countTick),
    .underflowTick(underflowTick), .waveformPin(waveformPin),
    .preReg(preReg), .priReg(priReg), .secReg(secReg),
    .modeReg(modeReg), .running(running), .badCount(badCount));

  // clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
      begin
      fail_count++;
      $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
    end
  endtask

  // one single ahb transfer, waits for hready in each phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clock); while (hready_q() !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready_q() !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic hready_q();
    return hreadyout;
  endfunction

  task automatic cmd(input logic [2:0] c);
    bus(1'b1, rtm_pkg::A_CMD, {29'h0000_0000, c});
    bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
    while (rd[rtm_pkg::ST_BUSY] !== 1'b0)
      bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
  endtask

  task automatic setup(input logic [1:0] m, input logic [7:0] p,
                       input logic [7:0] q, input logic [7:0] s);
    bus(1'b1, rtm_pkg::A_MODE, {30'h0000_0000, m});
    cmd(rtm_pkg::CMD_MODE);
    bus(1'b1, rtm_pkg::A_PRE, {24'h00_0000, p});
    bus(1'b1, rtm_pkg::A_PRI, {24'h00_0000, q});
    bus(1'b1, rtm_pkg::A_SEC, {24'h00_0000, s});
    cmd(rtm_pkg::CMD_LOAD);
  endtask

  task automatic t_regs();
    bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
    bus(1'b0, rtm_pkg::A_PRE, 32'h0000_0000);
    check(rd, 32'h0000_00FF);
    bus(1'b1, 8'h18, 32'h0000_0055);
    bus(1'b0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_timer();
    setup(rtm_pkg::MODE_TIMER, 8'h02, 8'h01, 8'h01);
    check({preReg, priReg, secReg}, 24'h02_0101);
    cmd(rtm_pkg::CMD_START);
    check(rd, 32'h0000_0008);
    setup(rtm_pkg::MODE_TIMER, 8'h03, 8'h04, 8'h01);
    check({preReg, priReg, badCount}, 24'h03_0400);
    cmd(rtm_pkg::CMD_STOP);
    check({preReg, priReg, 7'h00, running}, 24'hFF_FF00);
    $display("test timer done");
  endtask

  task automatic t_refuse();
    setup(rtm_pkg::MODE_OS, 8'h00, 8'h00, 8'h00);
    check({rd[3:0], priReg, badCount}, 20'h2_FF00);
    bus(1'b1, rtm_pkg::A_STAT, 32'h0000_0002);
    bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test refuse done");
  endtask

  task automatic t_wave();
    setup(rtm_pkg::MODE_WAVE, 8'h01, 8'h01, 8'h02);
    cmd(rtm_pkg::CMD_START);
    repeat (100)
    begin
      bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
      if (rd[rtm_pkg::ST_PIN] === 1'b1)
        break;
    end
    check(rd[rtm_pkg::ST_PIN], 1'b1);
    setup(rtm_pkg::MODE_WAVE, 8'h01, 8'h02, 8'h01);
    check({priReg, badCount}, 16'h0200);
    cmd(rtm_pkg::CMD_STOP);
    bus(1'b0, rtm_pkg::A_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test wave done");
  endtask

  task automatic t_oneshot();
    int n;
    n = 0;
    setup(rtm_pkg::MODE_WAIT, 8'h01, 8'h01, 8'h01);
    cmd(rtm_pkg::CMD_OSSTART);
    cmd(rtm_pkg::CMD_OSSTOP);
    check(badCount, 8'h00);
    setup(rtm_pkg::MODE_WAIT, 8'h01, 8'h02, 8'h01);
    bus(1'b1, rtm_pkg::A_CMD, {29'h0000_0000, rtm_pkg::CMD_TRIG});
    repeat (60)
    begin
      @(posedge clock);
      if (triggerPin === 1'b1)
        n++;
    end
    check(n, 3);
    check(badCount, 8'h00);
    $display("test oneshot done");
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (30000) @(posedge clock);
    fail_count++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial
  begin
    nrst = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_timer();
    t_refuse();
    t_wave();
    t_oneshot();
    close_out();
  end
endmodule // rtm_host_tb_top

`default_nettype wire
